// ### core/adcs_core.sv
// converter control core: serial register port, resets, coding, sequencer
module adcs_core #(
	parameter logic [15:0] RDY_CYC = 16'(adcs_pkg::RDY_DELAY_CYC)
) (
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic               i_sclk,
	input  wire logic               i_cs_n,
	input  wire logic               i_din,
	input  wire logic               i_conv_valid,
	input  wire logic signed [16:0] i_conv_raw,
	output logic                    o_dout,
	output logic                    o_ready,
	output logic                    o_core_reset,
	output logic                    o_conv_start,
	output logic [3:0]              o_current_channel,
	output logic [23:0]             o_current_cfg
);
	if (RDY_CYC < 16'h0001)
	begin : g_chk
		$error("ready delay must be at least one cycle");
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [4:0] seek(input logic [15:0] en, input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 15; i >= 0; i--)
			if (en[i] && 5'(i) >= from)
				r = 5'(i);
		return r;
	endfunction

	function automatic logic [15:0] code(input logic signed [16:0] raw, input logic ofs);
		logic signed [17:0] t;
		t = ofs ? (18'(raw) >>> 1) + 18'sh08000 : 18'(raw);
		if (t < 0)
			return adcs_pkg::CODE_ZERO;
		else if (t > 18'sh0ffff)
			return adcs_pkg::CODE_FULL;
		else
			return t[15:0];
	endfunction

	function automatic logic is_ch(input logic [5:0] a);
		return a >= adcs_pkg::REG_CH0 && a <= adcs_pkg::REG_CHLAST;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic [2:0] {ST_CMD = 3'b001, ST_WR = 3'b010, ST_RD = 3'b100} adcs_port_e;
	typedef enum logic [2:0] {SQ_IDLE = 3'b001, SQ_SETTLE = 3'b010, SQ_WAIT = 3'b100} adcs_seq_e;

	adcs_lnk_if lnk ();

	adcs_port_e  state_q, state_d;
	adcs_seq_e   seq_q, seq_d;
	logic [5:0]  bcnt_q, bcnt_d, addr_q, addr_d, wlen_q, wlen_d, settle_q, settle_d;
	logic [31:0] shin_q, shin_d, shout_q, shout_d;
	logic [6:0]  ones_q, ones_d;
	logic [15:0] rdycnt_q, rdycnt_d, ctrl_q, ctrl_d, data_q, data_d;
	logic [23:0] chan_q [adcs_pkg::NUM_CH];
	logic [23:0] chan_d [adcs_pkg::NUM_CH];
	logic [23:0] cfg_d;
	logic [15:0] en;
	logic [3:0]  data_ch_q, data_ch_d, cur_q, cur_d;
	logic        soft_q, soft_d, err_q, err_d, por_q, por_d, rdyn_q, rdyn_d;
	logic        dout_d, start_d, done_q, done_d;
	logic        rst, ready, take, ctrl_wr, err_clr, stat_rd, conv_done, nxt_found;
	logic [7:0]  status;
	logic [31:0] wv;
	logic [4:0]  nxt;

	adcs_link_sampler u_sampler (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_sclk    (i_sclk),
		.i_cs_n    (i_cs_n),
		.i_din     (i_din),
		.lnk       (lnk)
	);

	// power-up reset and the soft reset share one path
	assign rst         = !i_reset_n || soft_q;
	assign ready       = rdycnt_q == 16'h0000;
	assign take        = lnk.sel && lnk.rise && ready;
	assign lnk.sel_use = ctrl_q[adcs_pkg::CTRL_SELPIN];
	assign status      = {rdyn_q, err_q, 1'b0, por_q, data_ch_q};
	assign wv          = {shin_q[30:0], lnk.din};
	assign conv_done   = seq_q == SQ_WAIT && i_conv_valid;

	// ************************************************************
	// serial port and registers
	// ************************************************************
	always_comb
	begin
		state_d  = state_q;
		bcnt_d   = bcnt_q;
		addr_d   = addr_q;
		wlen_d   = wlen_q;
		shin_d   = shin_q;
		shout_d  = shout_q;
		ones_d   = ones_q;
		soft_d   = 1'b0;
		dout_d   = o_dout;
		ctrl_d   = ctrl_q;
		chan_d   = chan_q;
		data_d   = data_q;
		data_ch_d = data_ch_q;
		ctrl_wr  = 1'b0;
		err_clr  = 1'b0;
		stat_rd  = 1'b0;
		rdyn_d   = rdyn_q;
		rdycnt_d = ready ? rdycnt_q : rdycnt_q - 16'h0001;
		if (!lnk.sel)
		begin
			state_d = ST_CMD;
			bcnt_d  = 6'h00;
			ones_d  = 7'h00;
		end
		else if (lnk.rise)
		begin
			ones_d = lnk.din ? ones_q + 7'h01 : 7'h00;
			if (lnk.din && ones_q == adcs_pkg::SOFT_RST_ONES - 7'h01)
				soft_d = 1'b1;
		end
		if (lnk.sel && lnk.fall && state_q == ST_RD)
		begin
			dout_d  = shout_q[31];
			shout_d = {shout_q[30:0], 1'b0};
		end
		if (take)
		begin
			shin_d = wv;
			bcnt_d = bcnt_q + 6'h01;
			case (state_q)
				ST_CMD:
				begin
					if (bcnt_q == 6'h00 && lnk.din)
						bcnt_d = 6'h00;
					else if (bcnt_q == 6'h07)
					begin
						addr_d = wv[5:0];
						bcnt_d = 6'h00;
						wlen_d = 6'h08;
						if (wv[5:0] == adcs_pkg::REG_CTRL)
							wlen_d = 6'h10;
						else if (is_ch(wv[5:0]))
							wlen_d = 6'h18;
						else if (wv[5:0] == adcs_pkg::REG_DATA)
							wlen_d = ctrl_q[adcs_pkg::CTRL_APPEND] ? 6'h18 : 6'h10;
						state_d = wv[adcs_pkg::CMD_RW] ? ST_RD : ST_WR;
						shout_d = 32'h0;
						if (wv[5:0] == adcs_pkg::REG_STATUS)
						begin
							shout_d = {status, 24'h0};
							stat_rd = 1'b1;
						end
						else if (wv[5:0] == adcs_pkg::REG_CTRL)
							shout_d = {ctrl_q, 16'h0};
						else if (wv[5:0] == adcs_pkg::REG_DATA)
						begin
							shout_d = {data_q, 16'h0};
							if (ctrl_q[adcs_pkg::CTRL_APPEND])
							begin
								shout_d = {data_q, status, 8'h0};
								stat_rd = 1'b1;
							end
						end
						else if (wv[5:0] == adcs_pkg::REG_ID)
							shout_d = {adcs_pkg::ID_VALUE, 24'h0};
						else if (wv[5:0] == adcs_pkg::REG_ERR)
							shout_d = {7'h00, err_q, 24'h0};
						else if (is_ch(wv[5:0]))
							shout_d = {chan_q[4'(wv[5:0] - adcs_pkg::REG_CH0)], 8'h0};
						if (!wv[adcs_pkg::CMD_RW])
							stat_rd = 1'b0;
						if (wv[adcs_pkg::CMD_RW] && wv[5:0] == adcs_pkg::REG_DATA)
							rdyn_d = 1'b1;
					end
				end
				ST_WR:
				begin
					if (bcnt_q == wlen_q - 6'h01)
					begin
						state_d = ST_CMD;
						bcnt_d  = 6'h00;
						if (addr_q == adcs_pkg::REG_CTRL)
						begin
							ctrl_d  = wv[15:0] & adcs_pkg::CTRL_WMASK;
							ctrl_wr = 1'b1;
						end
						else if (addr_q == adcs_pkg::REG_ERR)
							err_clr = wv[adcs_pkg::ERR_EARLY];
						else if (is_ch(addr_q))
							chan_d[4'(addr_q - adcs_pkg::REG_CH0)] = wv[23:0];
					end
				end
				default:
				begin
					if (bcnt_q == wlen_q - 6'h01)
					begin
						state_d = ST_CMD;
						bcnt_d  = 6'h00;
					end
				end
			endcase
		end
		if (conv_done)
		begin
			data_d    = code(i_conv_raw, ctrl_q[adcs_pkg::CTRL_CODING]);
			data_ch_d = cur_q;
			rdyn_d    = 1'b0;
		end
		// a new early access beats a clear in the same cycle
		err_d = (lnk.sel && lnk.rise && !ready) ? 1'b1 : (err_clr ? 1'b0 : err_q);
		por_d = stat_rd ? 1'b0 : por_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (rst)
		begin
			state_q   <= ST_CMD;
			bcnt_q    <= 6'h00;
			addr_q    <= 6'h00;
			wlen_q    <= 6'h08;
			shin_q    <= 32'h0;
			shout_q   <= 32'h0;
			ones_q    <= 7'h00;
			soft_q    <= 1'b0;
			o_dout    <= 1'b1;
			rdycnt_q  <= RDY_CYC;
			ctrl_q    <= adcs_pkg::CTRL_RST;
			for (int i = 0; i < adcs_pkg::NUM_CH; i++)
				chan_q[i] <= (i == 0) ? adcs_pkg::CH0_RST : adcs_pkg::CHN_RST;
			data_q    <= 16'h0000;
			data_ch_q <= 4'h0;
			err_q     <= 1'b0;
			por_q     <= 1'b1;
			rdyn_q    <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			bcnt_q    <= bcnt_d;
			addr_q    <= addr_d;
			wlen_q    <= wlen_d;
			shin_q    <= shin_d;
			shout_q   <= shout_d;
			ones_q    <= ones_d;
			soft_q    <= soft_d;
			o_dout    <= dout_d;
			rdycnt_q  <= rdycnt_d;
			ctrl_q    <= ctrl_d;
			chan_q    <= chan_d;
			data_q    <= data_d;
			data_ch_q <= data_ch_d;
			err_q     <= err_d;
			por_q     <= por_d;
			rdyn_q    <= rdyn_d;
		end
	end

	// ************************************************************
	// channel sequencer
	// ************************************************************
	always_comb
	begin
		for (int i = 0; i < adcs_pkg::NUM_CH; i++)
			en[i] = chan_q[i][adcs_pkg::CH_ENABLE];
		seq_d     = seq_q;
		cur_d     = cur_q;
		settle_d  = settle_q;
		start_d   = 1'b0;
		done_d    = ctrl_wr ? 1'b0 : done_q;
		nxt       = seek(en, {1'b0, cur_q} + 5'h01);
		nxt_found = !nxt[4];
		case (seq_q)
			SQ_IDLE:
			begin
				nxt = seek(en, 5'h00);
				if ((ctrl_q[adcs_pkg::CTRL_MODE +: 4] == adcs_pkg::MODE_CONT ||
					(ctrl_q[adcs_pkg::CTRL_MODE +: 4] == adcs_pkg::MODE_SINGLE && !done_q))
					&& !nxt[4])
				begin
					cur_d    = nxt[3:0];
					settle_d = 6'h00;
					seq_d    = SQ_SETTLE;
				end
			end
			SQ_SETTLE:
			begin
				settle_d = settle_q + 6'h01;
				if (settle_q == adcs_pkg::SETTLE_CYC - 6'h01)
				begin
					start_d = 1'b1;
					seq_d   = SQ_WAIT;
				end
			end
			default:
			begin
				if (i_conv_valid)
				begin
					settle_d = 6'h00;
					if (nxt_found)
					begin
						cur_d = nxt[3:0];
						seq_d = SQ_SETTLE;
					end
					else
					begin
						// wrap in continuous mode via idle, which picks the lowest
						seq_d  = SQ_IDLE;
						done_d = ctrl_q[adcs_pkg::CTRL_MODE +: 4] == adcs_pkg::MODE_SINGLE;
					end
				end
			end
		endcase
		cfg_d = chan_q[cur_d];
	end

	always_ff @(posedge i_clk)
	begin
		if (rst)
		begin
			seq_q             <= SQ_IDLE;
			cur_q             <= 4'h0;
			settle_q          <= 6'h00;
			done_q            <= 1'b0;
			o_conv_start      <= 1'b0;
			o_current_cfg     <= 24'h0;
			o_ready           <= 1'b0;
			o_core_reset      <= 1'b1;
		end
		else
		begin
			seq_q             <= seq_d;
			cur_q             <= cur_d;
			settle_q          <= settle_d;
			done_q            <= done_d;
			o_conv_start      <= start_d;
			o_current_cfg     <= cfg_d;
			o_ready           <= ready;
			o_core_reset      <= 1'b0;
		end
	end

	assign o_current_channel = cur_q;

	// ************************************************************
	// checks
	// ************************************************************
	AST_ID_READ: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state_q == ST_RD && $past(state_q) == ST_CMD && addr_q == adcs_pkg::REG_ID)
		|-> shout_q[31:24] == adcs_pkg::ID_VALUE) else $error("identity value wrong");
	AST_SOFT_RESET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		soft_q |=> (ctrl_q == adcs_pkg::CTRL_RST && chan_q[0] == adcs_pkg::CH0_RST
		&& por_q && o_core_reset)) else $error("soft reset incomplete");
	AST_EARLY_DROP: assert property (@(posedge i_clk) disable iff (rst)
		(lnk.sel && lnk.rise && !ready) |=> err_q && $stable(bcnt_q))
		else $error("early access not flagged");
	AST_W1C_HOLD: assert property (@(posedge i_clk) disable iff (rst)
		(err_q && !err_clr) |=> err_q) else $error("error flag lost");
	AST_POR_CLEAR: assert property (@(posedge i_clk) disable iff (rst)
		stat_rd |=> !por_q) else $error("reset flag not cleared");
	AST_POWERUP: assert property (@(posedge i_clk)
		$rose(i_reset_n) |-> (por_q && !o_ready && rdycnt_q == RDY_CYC))
		else $error("power-up reset missing");
	AST_OFFSET_ZERO: assert property (@(posedge i_clk) disable iff (rst)
		(conv_done && ctrl_q[adcs_pkg::CTRL_CODING] && i_conv_raw == 17'sh0)
		|=> data_q == adcs_pkg::CODE_MID) else $error("offset zero code wrong");
	AST_CLAMP_NEG: assert property (@(posedge i_clk) disable iff (rst)
		(conv_done && !ctrl_q[adcs_pkg::CTRL_CODING] && i_conv_raw < 0)
		|=> data_q == adcs_pkg::CODE_ZERO) else $error("negative input not clamped");
	AST_ASCEND: assert property (@(posedge i_clk) disable iff (rst)
		(conv_done && nxt_found) |=> cur_q > $past(cur_q)) else $error("sequence not ascending");
	AST_SETTLE: assert property (@(posedge i_clk) disable iff (rst)
		$rose(seq_q == SQ_SETTLE) |-> !o_conv_start [*8] ##25 o_conv_start)
		else $error("settling time wrong");
	AST_CMD_GATE: assert property (@(posedge i_clk) disable iff (rst)
		(take && state_q == ST_CMD && bcnt_q == 6'h00 && lnk.din)
		|=> (state_q == ST_CMD && bcnt_q == 6'h00)) else $error("gated command clocked");
	AST_RETURN: assert property (@(posedge i_clk) disable iff (rst)
		(take && state_q != ST_CMD && bcnt_q == wlen_q - 6'h01) |=> state_q == ST_CMD)
		else $error("port did not return to command");
	AST_ABORT: assert property (@(posedge i_clk) disable iff (rst)
		(!lnk.sel && ctrl_q == $past(ctrl_q)) |=> (state_q == ST_CMD && bcnt_q == 6'h00
		&& ctrl_q == $past(ctrl_q))) else $error("abort failed");
endmodule

// ### core/adcs_pkg.sv
// constants for the converter control core and channel sequencer
// Behaviour
// - read-only identity register at 0x05 lets the host confirm the link.
// - sixty-four consecutive ones reset interface, filter, modulator and all registers.
// - early transactions are dropped and set the early-access error flag.
// - early-access flag is readable and clears only by writing one.
// - reset-seen flag sets on every reset and clears when read.
// - power-up performs the same full reset without a host command.
// - coding-select bit resets to one, selecting offset-binary coding.
// - offset binary maps zero to 0x8000, full scale 0xffff, negative 0x0000.
// - straight binary clamps negative differential inputs to 0x0000.
// - straight code is 2^16*in*gain/ref; offset code is 2^15*(that ratio+1).
// - with append set, results are data word followed by status byte.
// - status low nibble names result channel; also reset-seen and error summary.
// - channel 0 resets to 0x800100, all others to 0x000100.
// - sixteen channel registers; enabled ones join the sequence.
// - channel register holds inputs, excitation pins, setup, switch, limit, enable.
// - sequencer steps enabled channels in ascending order.
// - each selected channel settles 32 clock cycles before converting.
// - every transaction starts with a command byte: gate, read/write, target.
// - gate bit high stops the command byte from clocking in.
// - after the data phase the port waits for a new command.
// - chip select high aborts the transfer without touching registers.
package adcs_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [5:0]  REG_STATUS = 6'h00;
	localparam logic [5:0]  REG_CTRL   = 6'h01;
	localparam logic [5:0]  REG_DATA   = 6'h02;
	localparam logic [5:0]  REG_ID     = 6'h05;
	localparam logic [5:0]  REG_ERR    = 6'h06;
	localparam logic [5:0]  REG_CH0    = 6'h09;
	localparam logic [5:0]  REG_CHLAST = 6'h18;
	localparam int          NUM_CH     = 16;
	// arbitrary identity value
	localparam logic [7:0]  ID_VALUE   = 8'h5a;
	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int          CMD_GATE    = 7;
	localparam int          CMD_RW      = 6;
	localparam logic [15:0] CTRL_RST    = 16'h4000;
	localparam logic [15:0] CTRL_WMASK  = 16'h7f7f;
	localparam int          CTRL_CODING = 14;
	localparam int          CTRL_APPEND = 10;
	localparam int          CTRL_SELPIN = 9;
	localparam int          CTRL_MODE   = 2;
	localparam logic [3:0]  MODE_CONT   = 4'h0;
	localparam logic [3:0]  MODE_SINGLE = 4'h1;
	localparam logic [23:0] CH0_RST     = 24'h800100;
	localparam logic [23:0] CHN_RST     = 24'h000100;
	localparam int          CH_ENABLE   = 23;
	localparam int          ERR_EARLY   = 0;
	localparam logic [15:0] CODE_ZERO   = 16'h0000;
	localparam logic [15:0] CODE_MID    = 16'h8000;
	localparam logic [15:0] CODE_FULL   = 16'hffff;
	// ************************************************************
	// timing
	// ************************************************************
	localparam logic [6:0]  SOFT_RST_ONES  = 7'h40;
	localparam logic [5:0]  SETTLE_CYC     = 6'h20;
	localparam int          CLK_MHZ        = 100;
	localparam int          RDY_DELAY_NS   = 1000;
	localparam int          RDY_DELAY_CYC  = (RDY_DELAY_NS * CLK_MHZ + 999) / 1000;
endpackage

// ### core/adcs_lnk_if.sv
// sampled serial link events passed from the sampler to the core
interface adcs_lnk_if;
	logic rise;
	logic fall;
	logic din;
	logic sel;
	logic sel_use;
	modport src (output rise, output fall, output din, output sel, input sel_use);
	modport dst (input rise, input fall, input din, input sel, output sel_use);
endinterface

// ### core/adcs_link_sampler.sv
// synchronises the serial pins and finds clock edges
module adcs_link_sampler (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_sclk,
	input  wire logic i_cs_n,
	input  wire logic i_din,
	adcs_lnk_if.src   lnk
);
	logic [2:0] sclk_q;
	logic [2:0] sclk_d;
	logic [1:0] cs_q;
	logic [1:0] cs_d;
	logic [1:0] din_q;
	logic [1:0] din_d;

	always_comb
	begin
		sclk_d = {sclk_q[1:0], i_sclk};
		cs_d   = {cs_q[0], i_cs_n};
		din_d  = {din_q[0], i_din};
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			sclk_q <= 3'h7;
			cs_q   <= 2'h3;
			din_q  <= 2'h0;
		end
		else
		begin
			sclk_q <= sclk_d;
			cs_q   <= cs_d;
			din_q  <= din_d;
		end
	end

	// only stages two and three are looked at, never the first
	assign lnk.rise = sclk_q[1] & ~sclk_q[2];
	assign lnk.fall = ~sclk_q[1] & sclk_q[2];
	assign lnk.din  = din_q[1];
	// three-wire use: the select pin is ignored
	assign lnk.sel  = lnk.sel_use ? ~cs_q[1] : 1'b1;
endmodule

// ### bench/adcs_host_model.sv
// host-side serial port model, mode 3, for the converter control core
module adcs_host_model (
	input  wire logic   i_clk,
	input  wire logic   i_dout,
	output logic        o_sclk,
	output logic        o_cs_n,
	output logic        o_din,
	output logic        o_done,
	output logic [63:0] o_rx
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din  = 1'b0;
		o_done = 1'b0;
		o_rx   = 64'h0;
	end

	// ************************************************************
	// one frame: n bits msb first, sclk idles high between frames
	// ************************************************************
	task automatic xfer(input int n, input logic [63:0] tx);
		int i;
		@(negedge i_clk);
		o_cs_n = 1'b0;
		o_rx   = 64'h0;
		repeat (8) @(negedge i_clk);
		for (i = n - 1; i >= 0; i--)
		begin
			o_sclk = 1'b0;
			o_din  = tx[i];
			repeat (8) @(negedge i_clk);
			o_sclk = 1'b1;
			o_rx   = {o_rx[62:0], i_dout};
			repeat (8) @(negedge i_clk);
		end
		// released line must not keep its last level
		o_cs_n = 1'b1;
		o_din  = ~o_din;
		o_done = 1'b1;
		@(negedge i_clk);
		o_done = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the converter control core
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {string nm; logic [63:0] ex; logic [63:0] m;} adcs_note_s;

	logic               i_clk = 1'b0;
	logic               i_reset_n;
	logic               i_conv_valid;
	logic signed [16:0] i_conv_raw;
	logic               sclk;
	logic               cs_n;
	logic               din;
	logic               dout;
	logic               o_ready;
	logic               o_core_reset;
	logic               o_conv_start;
	logic [3:0]         o_current_channel;
	logic [23:0]        o_current_cfg;
	logic               done;
	logic [63:0]        rx;
	int                 fail_count = 0;
	int                 checked = 0;
	adcs_note_s         notes[$];
	int                 exp_ch[$];
	logic [23:0]        chv[16];
	int                 cnt = 0;
	bit                 armed = 0;
	logic [3:0]         prev_ch = 4'h0;
	int                 seq[3] = '{0, 3, 7};
	int                 tab[5] = '{0, 65534, -65536, 32768, -2};
	int                 raw;

	always #5 i_clk = ~i_clk;

	adcs_core #(.RDY_CYC(16'h012c)) uut (
		.i_clk             (i_clk),
		.i_reset_n         (i_reset_n),
		.i_sclk            (sclk),
		.i_cs_n            (cs_n),
		.i_din             (din),
		.i_conv_valid      (i_conv_valid),
		.i_conv_raw        (i_conv_raw),
		.o_dout            (dout),
		.o_ready           (o_ready),
		.o_core_reset      (o_core_reset),
		.o_conv_start      (o_conv_start),
		.o_current_channel (o_current_channel),
		.o_current_cfg     (o_current_cfg)
	);

	adcs_host_model host (
		.i_clk  (i_clk),
		.i_dout (dout),
		.o_sclk (sclk),
		.o_cs_n (cs_n),
		.o_din  (din),
		.o_done (done),
		.o_rx   (rx)
	);

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim;
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] sn);
		checked++;
		if (ex !== sn)
		begin
			$display("Error %s expected %h seen %h", nm, ex, sn);
			fail_count++;
		end
	endtask

	task automatic acc(input string nm, input int n, input logic [63:0] tx,
		input logic [63:0] ex, input logic [63:0] m);
		notes.push_back('{nm, ex & m, m});
		host.xfer(n, tx);
	endtask

	task automatic rd(input string nm, input logic [5:0] a, input int n, input logic [63:0] ex);
		acc(nm, n + 8, {56'h0, 2'b01, a} << n, ex, (64'h1 << n) - 64'h1);
	endtask

	task automatic wr(input logic [5:0] a, input int n, input logic [63:0] v);
		acc("write", n + 8, ({56'h0, 2'b00, a} << n) | v, 64'h0, 64'h0);
	endtask

	// bounded wait for ready (rdy=1) or a conversion start (rdy=0)
	task automatic wait_hi(input bit rdy);
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(negedge i_clk);
			if (rdy ? o_ready === 1'b1 : o_conv_start === 1'b1)
				break;
		end
		if (i == 3000)
		begin
			chk("wait", 64'h1, 64'h0);
			end_sim();
		end
	endtask

	task automatic conv(input int r);
		@(negedge i_clk);
		i_conv_valid = 1'b1;
		i_conv_raw   = 17'(r);
		@(negedge i_clk);
		i_conv_valid = 1'b0;
	endtask

	function automatic logic [15:0] code_of(input bit off, input int r);
		int v;
		v = off ? r / 2 + 32768 : r;
		if (v < 0)
			v = 0;
		if (v > 65535)
			v = 65535;
		return v[15:0];
	endfunction

	// ************************************************************
	// monitors
	// ************************************************************
	always @(posedge i_clk)
	begin : mon_port
		adcs_note_s n;
		if (done === 1'b1 && notes.size() > 0)
		begin
			n = notes.pop_front();
			if (n.m != 64'h0)
				chk(n.nm, n.ex, rx & n.m);
		end
	end

	always @(negedge i_clk)
	begin : mon_seq
		int e;
		if (o_current_channel !== prev_ch)
		begin
			cnt   = 0;
			armed = 1;
		end
		else
			cnt++;
		prev_ch = o_current_channel;
		if (o_conv_start === 1'b1)
		begin
			if (exp_ch.size() > 0)
			begin
				e = exp_ch.pop_front();
				chk("channel", 64'(e), 64'(o_current_channel));
				chk("config", 64'(chv[e]), 64'(o_current_cfg));
				if (armed)
					chk("settle", 64'(adcs_pkg::SETTLE_CYC), 64'(cnt));
			end
			armed = 0;
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		i_reset_n    = 1'b0;
		i_conv_valid = 1'b0;
		i_conv_raw   = 17'h0;
		void'($urandom(99));
		for (int i = 0; i < 16; i++)
			chv[i] = (i == 0) ? adcs_pkg::CH0_RST : adcs_pkg::CHN_RST;
		repeat (6) @(negedge i_clk);
		i_reset_n = 1'b1;
		wait_hi(1);
		rd("status", adcs_pkg::REG_STATUS, 8, 64'h10);
		rd("status", adcs_pkg::REG_STATUS, 8, 64'h00);
		rd("id", adcs_pkg::REG_ID, 8, 64'(adcs_pkg::ID_VALUE));
		acc("gated", 17, {47'h0, 1'b1, 2'b01, adcs_pkg::REG_ID, 8'h00},
			64'(adcs_pkg::ID_VALUE), 64'hff);
		rd("unmapped", 6'h3f, 8, 64'h0);
		rd("control", adcs_pkg::REG_CTRL, 16, 64'(adcs_pkg::CTRL_RST));
		for (int i = 0; i < adcs_pkg::NUM_CH; i++)
			rd("channel", adcs_pkg::REG_CH0 + 6'(i), 24, 64'(chv[i]));
		wr(adcs_pkg::REG_CTRL, 16, 64'hffff);
		rd("control", adcs_pkg::REG_CTRL, 16, 64'(adcs_pkg::CTRL_WMASK));
		wr(adcs_pkg::REG_CTRL, 16, 64'h4600);
		acc("abort", 12, 64'h01f, 64'h0, 64'h0);
		rd("control", adcs_pkg::REG_CTRL, 16, 64'h4600);
		for (int j = 1; j < 3; j++)
		begin
			chv[seq[j]] = 24'($urandom) | 24'h800000;
			wr(adcs_pkg::REG_CH0 + 6'(seq[j]), 24, 64'(chv[seq[j]]));
			rd("channel", adcs_pkg::REG_CH0 + 6'(seq[j]), 24, 64'(chv[seq[j]]));
		end
		wr(adcs_pkg::REG_CTRL, 16, 64'h4400);
		repeat (40) @(negedge i_clk);
		for (int k = 0; k < 6; k++)
		begin
			if (k == 3)
				wr(adcs_pkg::REG_CTRL, 16, 64'h0400);
			raw = (k == 5) ? int'($urandom_range(0, 65535)) * 2 - 65536 : tab[k];
			exp_ch.push_back(seq[(k + 1) % 3]);
			conv(raw);
			wait_hi(0);
			acc("data", 32, {56'h0, 2'b01, adcs_pkg::REG_DATA} << 24,
				{40'h0, code_of(k < 3, raw), 4'h0, 4'(seq[k % 3])},
				64'hffff7f);
		end
		// single sequence: one pass, then idle until the control register is written again
		wr(adcs_pkg::REG_CTRL, 16, 64'h0404);
		for (int k = 1; k < 4; k++)
		begin
			if (k < 3)
				exp_ch.push_back(seq[k]);
			conv(tab[k]);
			if (k < 3)
				wait_hi(0);
		end
		raw = 0;
		repeat (60)
		begin
			@(negedge i_clk);
			if (o_conv_start === 1'b1)
				raw++;
		end
		chk("single", 64'h0, 64'(raw));
		exp_ch.push_back(0);
		wr(adcs_pkg::REG_CTRL, 16, 64'h0404);
		wait_hi(0);
		acc("soft reset", 64, ~64'h0, 64'h0, 64'h0);
		acc("early", 8, {56'h0, 2'b01, adcs_pkg::REG_ID}, 64'h0, 64'h0);
		wait_hi(1);
		acc("status", 16, {56'h0, 2'b01, adcs_pkg::REG_STATUS} << 8, 64'h10, 64'hbf);
		rd("control", adcs_pkg::REG_CTRL, 16, 64'(adcs_pkg::CTRL_RST));
		rd("channel", adcs_pkg::REG_CH0 + 6'h03, 24, 64'(adcs_pkg::CHN_RST));
		rd("error", adcs_pkg::REG_ERR, 8, 64'h1);
		wr(adcs_pkg::REG_ERR, 8, 64'h0);
		rd("error", adcs_pkg::REG_ERR, 8, 64'h1);
		wr(adcs_pkg::REG_ERR, 8, 64'h1);
		rd("error", adcs_pkg::REG_ERR, 8, 64'h0);
		@(negedge i_clk);
		i_reset_n = 1'b0;
		repeat (6) @(negedge i_clk);
		chk("core reset", 64'h1, 64'(o_core_reset));
		chk("ready", 64'h0, 64'(o_ready));
		i_reset_n = 1'b1;
		wait_hi(1);
		rd("status", adcs_pkg::REG_STATUS, 8, 64'h10);
		chk("core reset", 64'h0, 64'(o_core_reset));
		end_sim();
	end
endmodule
